// ---- rtl/mds_device.sv ----
// Coprocessor end: instruction sequencer, operand registers, multiply and divide.
// Assumes host changes code and select just after the rising edge of MCLK.
//
// Notes on behaviour
// - Host changes code and select only clock-high.
// - Overflow sets on any selected code in states 8 and 10; upper result on bus only for read.
// - Repeated read code swaps halves each cycle.
// - Code 6 loads multiplier; code 7 drives bus.
// - Read during last multiply; halves follow directly.
// - Read code while deselected: no drive, no advance, but clears overflow in state 0.
// - Deselected: no multiplier load, no bus drive.
// - State 12 code 6 loads, goes state 8.
// - Multiplier loads while multiplication still runs.
// - Simple product: load, multiplicand, wait, read twice.
// - Multiplier retained; multiplicand alone restarts multiply.
// - Three loads add a 32-bit constant.
// - Divide: divisor, high, low starts; read twice.
// - Deselected in wait states holds state.
// - Overflow clears only on listed read transitions.
`timescale 1ns/1ns
`default_nettype none
`include "mds_map.svh"

module mds_device
    import mds_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Link to host
    mds_if.device link,
    // Status
    output logic OVERFLOW,
    output logic [3:0] STATE
);

    // States in which a deselected device waits, and the overflow clear set
    function automatic logic hold_state(mds_state_t s);
        return s inside {ST_IDLE, ST_XLD, ST_RDW, ST_MLAST, ST_DLAST, ST_SWAP};
    endfunction

    function automatic logic clear_state(mds_state_t s);
        return s inside {ST_IDLE, ST_RDW, ST_MLAST, ST_DLAST, ST_SWAP};
    endfunction

    mds_state_t st_q, st_d, cur;
    logic [4:0] cnt_q, cnt_d;
    logic [DW-1:0] x_q, x_d, z_q, z_d, w_q, w_d, bus_q, bus_d;
    logic bus_oe_n_q, bus_oe_n_d;
    logic ovf_q, ovf_d, pend_q, pend_d;
    logic sel, ovf_set, ovf_clr, add_acc;
    mds_code_t code;
    logic signed [2*DW:0] prod_s, mac_s;
    logic signed [2*DW-1:0] dvd_s, dvs_s, quo_s, rem_s;
    logic mac_ovf, div_ovf;

    assign sel = !link.go_n;
    assign code = mds_code_t'(link.instr_code);

    // Arithmetic: multiply-accumulate on the bus operand, divide of Z,W by X
    always_comb begin
        prod_s = (2*DW+1)'($signed(x_q) * $signed(link.bus));
        if (code == CODE_NMUL || code == CODE_NMAC) begin
            prod_s = -prod_s;
        end
        mac_s = add_acc ? prod_s + (2*DW+1)'($signed({z_q, w_q})) : prod_s;
        mac_ovf = mac_s[2*DW] != mac_s[2*DW-1];
        // Dividend low half comes straight off the bus when code 4 follows the Z load
        dvd_s = (st_q == ST_ZLD) ? $signed({z_q, link.bus}) : $signed({z_q, w_q});
        // Zero divisor replaced to keep the operator defined; flagged as overflow
        dvs_s = (x_q == '0) ? (2*DW)'(1) : (2*DW)'($signed(x_q));
        quo_s = dvd_s / dvs_s;
        rem_s = dvd_s % dvs_s;
        div_ovf = (x_q == '0) || !((&quo_s[2*DW-1:DW-1]) || !(|quo_s[2*DW-1:DW-1]));
    end

    always_comb begin
        // Non-read codes in the read-out states behave as in idle
        cur = ((st_q == ST_RDW || st_q == ST_SWAP) && code != CODE_READ) ? ST_IDLE : st_q;
        st_d = st_q;
        cnt_d = cnt_q;
        x_d = x_q;
        z_d = z_q;
        w_d = w_q;
        pend_d = pend_q;
        ovf_set = 1'b0;
        add_acc = 1'b0;
        bus_oe_n_d = 1'b1;
        bus_d = bus_q;
        // Any selected read code drives the bus, whatever the state
        if (sel && code == CODE_READ) begin
            bus_oe_n_d = 1'b0;
            bus_d = z_q;
        end
        unique case (cur)
            ST_IDLE, ST_XLD, ST_ZLD, ST_KLD: begin
                if (sel) begin
                    unique case (code)
                        CODE_LOAD: begin
                            if (cur == ST_XLD) begin
                                z_d = link.bus;
                                st_d = ST_ZLD;
                            end else if (cur == ST_ZLD) begin
                                w_d = link.bus;
                                st_d = ST_KLD;
                            end else begin
                                x_d = link.bus;
                                st_d = ST_XLD;
                            end
                        end
                        CODE_MUL, CODE_NMUL, CODE_MAC, CODE_NMAC: begin
                            add_acc = code[1] || cur == ST_KLD;
                            {z_d, w_d} = mac_s[2*DW-1:0];
                            pend_d = mac_ovf;
                            cnt_d = `MDS_MUL_CYCLES;
                            st_d = ST_MUL;
                        end
                        CODE_DIV: begin
                            z_d = quo_s[DW-1:0];
                            w_d = rem_s[DW-1:0];
                            pend_d = div_ovf;
                            cnt_d = `MDS_DIV_CYCLES;
                            st_d = ST_DIV;
                        end
                        CODE_READ: begin
                            st_d = ST_RDW;
                        end
                        CODE_RND: begin
                            st_d = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_MUL, ST_DIV: begin
                // Iterations run on regardless of select
                cnt_d = cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    st_d = (cur == ST_MUL) ? ST_ACC : ST_DLAST;
                end
                if (sel && code == CODE_LOAD) begin
                    x_d = link.bus;
                end
            end
            ST_ACC: begin
                if (sel && code == CODE_LOAD) begin
                    x_d = link.bus;
                end
                st_d = ST_MLAST;
            end
            ST_MLAST, ST_DLAST: begin
                if (sel) begin
                    ovf_set = pend_q;
                    pend_d = 1'b0;
                    st_d = ST_IDLE;
                    unique case (code)
                        CODE_READ: begin
                            st_d = ST_RDW;
                        end
                        CODE_MUL, CODE_NMUL, CODE_MAC, CODE_NMAC: begin
                            if (cur == ST_MLAST) begin
                                add_acc = code[1];
                                {z_d, w_d} = mac_s[2*DW-1:0];
                                pend_d = mac_ovf;
                                cnt_d = `MDS_MUL_CYCLES;
                                st_d = ST_MUL;
                            end
                        end
                        CODE_RND: begin
                            // Multiply: add W msb into Z; divide: force quotient lsb unless exact
                            if (cur == ST_MLAST) begin
                                z_d = z_q + {{(DW-1){1'b0}}, w_q[DW-1]};
                            end else if (w_q != '0) begin
                                z_d = {z_q[DW-1:1], 1'b1};
                            end
                            w_d = '0;
                        end
                        CODE_LOAD: begin
                            x_d = link.bus;
                            st_d = ST_XLD;
                        end
                        CODE_DIV: begin
                        end
                    endcase
                end
            end
            ST_RDW, ST_SWAP: begin
                // Only reached with the read code; later reads alternate the halves
                if (sel) begin
                    bus_d = w_q;
                    z_d = w_q;
                    w_d = z_q;
                    st_d = (cur == ST_RDW) ? ST_SWAP : ST_RDW;
                end
            end
        endcase
        if (!sel && hold_state(st_q)) begin
            st_d = st_q;
        end
        ovf_clr = clear_state(st_q) && st_d == ST_IDLE && code == CODE_READ;
        ovf_d = (ovf_q && !ovf_clr) || ovf_set;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            st_q <= ST_IDLE;
            cnt_q <= 5'h00;
            x_q <= '0;
            z_q <= '0;
            w_q <= '0;
            bus_q <= '0;
            bus_oe_n_q <= 1'b1;
            ovf_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            x_q <= x_d;
            z_q <= z_d;
            w_q <= w_d;
            bus_q <= bus_d;
            bus_oe_n_q <= bus_oe_n_d;
            ovf_q <= ovf_d;
            pend_q <= pend_d;
        end
    end

    assign link.dev_bus_out = bus_q;
    assign link.dev_bus_oe_n = bus_oe_n_q;
    assign link.overflow_flag = ovf_q;
    assign OVERFLOW = ovf_q;
    assign STATE = st_q;

endmodule

`default_nettype wire

// ---- rtl/mds_host.sv ----
// Host end: presents one instruction per clock and collects read results.
// Assumes the user keeps codes apart as the coprocessor sequence needs.
`timescale 1ns/1ns
`default_nettype none
`include "mds_map.svh"

module mds_host
    import mds_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Link to coprocessor
    mds_if.host link,
    // Requests, one per cycle while valid
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_CODE,
    input wire logic [DW-1:0] REQ_DATA,
    // Read results
    output logic RSP_VALID,
    output logic [DW-1:0] RSP_DATA,
    output logic OVERFLOW
);

    function automatic logic uses_bus(logic [2:0] c);
        return !(c == `MDS_CODE_RND || c == `MDS_CODE_READ);
    endfunction

    logic [2:0] code_q, code_d;
    logic go_n_q, go_n_d, hoe_n_q, hoe_n_d;
    logic [DW-1:0] data_q, data_d, rsp_q, rsp_d;
    logic rd1_q, rd1_d, rd2_q, rd2_d, rsp_v_q, rsp_v_d, ovf_q, ovf_d;

    always_comb begin
        // Registered at the rising edge, so code and select change while clock is high
        // Code lines follow the request even when deselected, like address bits
        code_d = REQ_CODE;
        go_n_d = !REQ_VALID;
        data_d = REQ_DATA;
        // Never drive in the cycle the coprocessor answers a read
        hoe_n_d = !(REQ_VALID && uses_bus(REQ_CODE) && !rd1_q);
        rd1_d = REQ_VALID && REQ_CODE == `MDS_CODE_READ;
        rd2_d = rd1_q;
        rsp_v_d = rd2_q;
        rsp_d = rd2_q ? link.bus : rsp_q;
        ovf_d = link.overflow_flag;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            code_q <= 3'h0;
            go_n_q <= 1'b1;
            hoe_n_q <= 1'b1;
            data_q <= '0;
            rd1_q <= 1'b0;
            rd2_q <= 1'b0;
            rsp_v_q <= 1'b0;
            rsp_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            code_q <= code_d;
            go_n_q <= go_n_d;
            hoe_n_q <= hoe_n_d;
            data_q <= data_d;
            rd1_q <= rd1_d;
            rd2_q <= rd2_d;
            rsp_v_q <= rsp_v_d;
            rsp_q <= rsp_d;
            ovf_q <= ovf_d;
        end
    end

    assign link.instr_code = code_q;
    assign link.go_n = go_n_q;
    assign link.host_bus_out = data_q;
    assign link.host_bus_oe_n = hoe_n_q;
    assign RSP_VALID = rsp_v_q;
    assign RSP_DATA = rsp_q;
    assign OVERFLOW = ovf_q;

endmodule

`default_nettype wire

// ---- rtl/mds_if.sv ----
// Link between host and coprocessor: code, select, shared data bus, overflow.
// Assumes one common clock; the bus level is resolved here from both enables.
`timescale 1ns/1ns
`default_nettype none

interface mds_if #(parameter int DW = 16) ();
    logic [2:0] instr_code;
    logic go_n;
    logic [DW-1:0] host_bus_out;
    logic host_bus_oe_n;
    logic [DW-1:0] dev_bus_out;
    logic dev_bus_oe_n;
    logic [DW-1:0] bus;
    logic overflow_flag;

    // Undriven bus floats high, as with a pull-up
    assign bus = !dev_bus_oe_n ? dev_bus_out : (!host_bus_oe_n ? host_bus_out : '1);

    modport device(input instr_code, go_n, bus,
        output dev_bus_out, dev_bus_oe_n, overflow_flag);
    modport host(output instr_code, go_n, host_bus_out, host_bus_oe_n,
        input bus, overflow_flag);
endinterface

`default_nettype wire

// ---- rtl/mds_map.svh ----
// Constants of the multiply/divide sequencer: instruction codes, state codes, counts.
// Assumes inclusion by bare name; definitions only.
`ifndef MDS_MAP_SVH
`define MDS_MAP_SVH

// Instruction codes presented by the host
`define MDS_CODE_MUL 3'h0
`define MDS_CODE_NMUL 3'h1
`define MDS_CODE_MAC 3'h2
`define MDS_CODE_NMAC 3'h3
`define MDS_CODE_DIV 3'h4
`define MDS_CODE_RND 3'h5
`define MDS_CODE_LOAD 3'h6
`define MDS_CODE_READ 3'h7

// State counter codes
`define MDS_ST_IDLE 4'b0000
`define MDS_ST_XLD 4'b0001
`define MDS_ST_ZLD 4'b0010
`define MDS_ST_RDW 4'b0011
`define MDS_ST_KLD 4'b0100
`define MDS_ST_MUL 4'b0101
`define MDS_ST_MLAST 4'b1000
`define MDS_ST_DIV 4'b1001
`define MDS_ST_DLAST 4'b1010
`define MDS_ST_SWAP 4'b1011
`define MDS_ST_ACC 4'b1100

// Iteration counts (cycles spent in the counting states)
`define MDS_MUL_CYCLES 5'h06
`define MDS_DIV_CYCLES 5'h12

`endif

// ---- rtl/mds_pkg.sv ----
// Types shared by both ends of the multiply/divide sequencer link.
// Assumes mds_map.svh is on the include path.
`include "mds_map.svh"

package mds_pkg;

    typedef enum logic [2:0] {
        CODE_MUL = `MDS_CODE_MUL,
        CODE_NMUL = `MDS_CODE_NMUL,
        CODE_MAC = `MDS_CODE_MAC,
        CODE_NMAC = `MDS_CODE_NMAC,
        CODE_DIV = `MDS_CODE_DIV,
        CODE_RND = `MDS_CODE_RND,
        CODE_LOAD = `MDS_CODE_LOAD,
        CODE_READ = `MDS_CODE_READ
    } mds_code_t;

    typedef enum logic [3:0] {
        ST_IDLE = `MDS_ST_IDLE,
        ST_XLD = `MDS_ST_XLD,
        ST_ZLD = `MDS_ST_ZLD,
        ST_RDW = `MDS_ST_RDW,
        ST_KLD = `MDS_ST_KLD,
        ST_MUL = `MDS_ST_MUL,
        ST_MLAST = `MDS_ST_MLAST,
        ST_DIV = `MDS_ST_DIV,
        ST_DLAST = `MDS_ST_DLAST,
        ST_SWAP = `MDS_ST_SWAP,
        ST_ACC = `MDS_ST_ACC
    } mds_state_t;

endpackage

// ---- testbench/mds_link_properties.sv ----
// Concurrent checks on the host/coprocessor link signals.
// Assumes one clock shared by both ends and an async active-high reset.
`timescale 1ns/1ns
`default_nettype none

module mds_link_properties (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Link signals
    input wire logic [2:0] instr_code,
    input wire logic go_n,
    input wire logic host_bus_oe_n,
    input wire logic [15:0] dev_bus_out,
    input wire logic dev_bus_oe_n,
    input wire logic overflow_flag
);
    logic sel_rd;

    assign sel_rd = !go_n && instr_code == 3'h7;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    property p_read_drive;
        sel_rd |=> !dev_bus_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("bus not driven after selected read");

    property p_desel_quiet;
        go_n |=> dev_bus_oe_n;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("bus driven while deselected");

    property p_release;
        !sel_rd |=> dev_bus_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("bus driven outside a read cycle");

    property p_no_fight;
        !(!dev_bus_oe_n && !host_bus_oe_n);
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the bus");

    // Third read returns the half seen two drives earlier
    property p_swap;
        sel_rd [*3] |=> dev_bus_out == $past(dev_bus_out, 2);
    endproperty
    a_swap: assert property (p_swap)
        else $error("result halves not alternating");

    property p_ovf_with_z;
        $rose(overflow_flag) |-> !dev_bus_oe_n;
    endproperty
    a_ovf_with_z: assert property (p_ovf_with_z)
        else $error("overflow set without upper half on bus");

    property p_ovf_sel;
        $rose(overflow_flag) |-> $past(sel_rd);
    endproperty
    a_ovf_sel: assert property (p_ovf_sel)
        else $error("overflow set without a selected read");

    property p_ovf_hold;
        overflow_flag && instr_code != 3'h7 |=> overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow cleared without read code");
endmodule

`default_nettype wire

// ---- testbench/tb_mul_div_instruction_sequencer.sv ----
// Self-checking bench: host and coprocessor joined by their link.
// Assumes the rtl files and mds_map.svh are compiled before this file.
`timescale 1ns/1ns
`default_nettype none

module tb_mul_div_instruction_sequencer
    import mds_pkg::*;
;
    logic mclk, reset, req_valid, rsp_valid, ovf_host, ovf_dev;
    logic [2:0] req_code;
    logic [15:0] req_data, rsp_data, a, b, c, d;
    logic [3:0] state;
    logic signed [31:0] e;
    logic [15:0] rq[$];
    int n_fail, checked, drv, d0;

    mds_if u_mds_if ();
    mds_device u_mds_device (.MCLK(mclk), .RESET(reset), .link(u_mds_if),
        .OVERFLOW(ovf_dev), .STATE(state));
    mds_host u_mds_host (.MCLK(mclk), .RESET(reset), .link(u_mds_if),
        .REQ_VALID(req_valid), .REQ_CODE(req_code), .REQ_DATA(req_data),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .OVERFLOW(ovf_host));
    mds_link_properties u_mds_link_properties (.MCLK(mclk), .RESET(reset),
        .instr_code(u_mds_if.instr_code), .go_n(u_mds_if.go_n),
        .host_bus_oe_n(u_mds_if.host_bus_oe_n), .dev_bus_out(u_mds_if.dev_bus_out),
        .dev_bus_oe_n(u_mds_if.dev_bus_oe_n), .overflow_flag(u_mds_if.overflow_flag));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Sampled mid-cycle so flop updates have settled
    always @(negedge mclk) begin
        if (rsp_valid === 1'b1) rq.push_back(rsp_data);
        if (u_mds_if.dev_bus_oe_n === 1'b0) drv++;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input logic v, input logic [2:0] cd, input logic [15:0] dt);
        @(posedge mclk);
        #1;
        req_valid = v;
        req_code = cd;
        req_data = dt;
    endtask

    // Idle cycles keep select high
    task automatic idle(input int n);
        repeat (n) step(1'b0, 3'h0, 16'h0000);
    endtask

    // Trailing idle lets answers arrive and keeps bus codes off the cycle after a read
    task automatic reads(input int n);
        repeat (n) step(1'b1, CODE_READ, 16'h0000);
        idle(4);
    endtask

    task automatic mul(input logic [15:0] x, input logic [15:0] y);
        step(1'b1, CODE_LOAD, x);
        step(1'b1, CODE_MUL, y);
        idle(7);
    endtask

    task automatic exp_rsp(input string name, input logic [15:0] ev);
        logic [15:0] v;
        v = (rq.size() > 0) ? rq.pop_front() : 16'hxxxx;
        check(name, {16'h0000, v}, {16'h0000, ev});
    endtask

    initial begin
        #10000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_code = 3'h0;
        req_data = 16'h0000;
        repeat (2) @(posedge mclk);
        #1;
        reset = 1'b0;
        check("state after reset", {28'h0, state}, {28'h0, ST_IDLE});
        a = 16'h1234;
        b = 16'hfffd;
        e = $signed(a) * $signed(b);
        d0 = drv;
        mul(a, b);
        reads(4);
        check("bus drive cycles", drv - d0, 32'h4);
        exp_rsp("product high", e[31:16]);
        exp_rsp("product low", e[15:0]);
        exp_rsp("swapped high", e[31:16]);
        exp_rsp("swapped low", e[15:0]);
        c = 16'h0007;
        e = $signed(a) * $signed(c);
        step(1'b1, CODE_MUL, c);
        idle(7);
        reads(2);
        exp_rsp("retained high", e[31:16]);
        exp_rsp("retained low", e[15:0]);
        a = 16'h0021;
        b = 16'h8011;
        e = $signed(a) * $signed(b);
        mul(a, b);
        d0 = drv;
        // Read code while deselected must neither drive nor advance
        repeat (3) step(1'b0, CODE_READ, 16'h0000);
        check("state while waiting", {28'h0, state}, {28'h0, ST_MLAST});
        reads(2);
        check("waited drive cycles", drv - d0, 32'h2);
        exp_rsp("waited high", e[31:16]);
        exp_rsp("waited low", e[15:0]);
        a = 16'hff00;
        b = 16'h0040;
        e = $signed(a) * $signed(b) + $signed(32'h1234_5678);
        step(1'b1, CODE_LOAD, a);
        step(1'b1, CODE_LOAD, 16'h1234);
        step(1'b1, CODE_LOAD, 16'h5678);
        step(1'b1, CODE_MUL, b);
        idle(7);
        reads(2);
        exp_rsp("constant high", e[31:16]);
        exp_rsp("constant low", e[15:0]);
        a = 16'h0003;
        b = 16'h0005;
        c = 16'hfffe;
        d = 16'h0009;
        e = $signed(a) * $signed(b) + $signed(c) * $signed(d) + $signed(a) * $signed(b);
        step(1'b1, CODE_LOAD, a);
        step(1'b1, CODE_MUL, b);
        idle(6);
        // Next multiplier lands in state 12, then accumulate from state 8
        step(1'b1, CODE_LOAD, c);
        step(1'b1, CODE_MAC, d);
        idle(5);
        // Next multiplier lands while the count still runs
        step(1'b1, CODE_LOAD, a);
        idle(1);
        step(1'b1, CODE_MAC, b);
        idle(7);
        reads(2);
        exp_rsp("sum high", e[31:16]);
        exp_rsp("sum low", e[15:0]);
        a = 16'h0070;
        b = 16'h0100;
        e = -($signed(a) * $signed(b));
        step(1'b1, CODE_LOAD, a);
        step(1'b1, CODE_NMUL, b);
        idle(7);
        step(1'b1, CODE_RND, 16'h0000);
        reads(2);
        exp_rsp("rounded high", e[31:16] + {15'h0, e[15]});
        exp_rsp("rounded low", 16'h0000);
        step(1'b1, CODE_LOAD, 16'h0100);
        step(1'b1, CODE_LOAD, 16'h0001);
        step(1'b1, CODE_DIV, 16'h2345);
        idle(18);
        reads(2);
        exp_rsp("quotient", 16'h0123);
        exp_rsp("remainder", 16'h0045);
        check("no overflow", {31'h0, ovf_dev}, 32'h0);
        step(1'b1, CODE_LOAD, 16'h0000);
        step(1'b1, CODE_LOAD, 16'h0001);
        step(1'b1, CODE_DIV, 16'h0000);
        idle(18);
        reads(2);
        rq.delete();
        check("overflow device", {31'h0, ovf_dev}, 32'h1);
        step(1'b1, CODE_LOAD, 16'h0001);
        idle(3);
        check("overflow held", {31'h0, ovf_host}, 32'h1);
        // Back to state 0, then read code while waiting there clears the flag
        step(1'b1, CODE_RND, 16'h0000);
        step(1'b0, CODE_READ, 16'h0000);
        idle(3);
        check("overflow cleared device", {31'h0, ovf_dev}, 32'h0);
        check("overflow cleared host", {31'h0, ovf_host}, 32'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
